// file: design/msoe_top.sv
// strap decode, host select and line driver tristate control
// Behaviour
// - host access only while select is low
// - jitter attenuator placed by three-level pin
// - bus style chosen by style pin
// - low codec pin enables substitution codes
// - high codec pin selects plain ami
// - global enable low tristates every driver
// - other logic keeps running while tristated
// - software bit one tristates its port in host mode only
// - strobe pin is strobe or write enable
`timescale 1ns/1ns
module msoe_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_mode,
  input wire logic unipolar,
  input wire logic chip_sel_n,
  input wire logic ja_sense_pu,
  input wire logic ja_sense_pd,
  input wire logic bus_style_sel,
  input wire logic line_code_sel,
  input wire logic strobe_pin,
  input wire logic rw_pin,
  input wire logic drv_enable,
  input wire logic [msoe_pkg::NPORT-1:0] output_enable_control,
  output msoe_pkg::msoe_host_t host_acc,
  output msoe_pkg::msoe_style_t bus_style,
  output logic [1:0] jitter_atten_position_sel,
  output msoe_pkg::msoe_code_t line_code,
  output msoe_pkg::msoe_drv_t tx_line_drv
);
  // strap and host pins pass two flops before use; drv_enable does not
  logic [7:0] s1_r, s2_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 8'h01;
      s2_r <= 8'h01;
    end else begin
      s1_r <= {ja_sense_pu, ja_sense_pd, bus_style_sel, line_code_sel,
               strobe_pin, rw_pin, host_mode, chip_sel_n};
      s2_r <= s1_r;
    end
  end
  logic pu_s, pd_s, style_s, code_s, stb_s, rw_s, hm_s, cs_n_s;
  assign {pu_s, pd_s, style_s, code_s, stb_s, rw_s, hm_s, cs_n_s} = s2_r;

  // three-level decode: pin probed with weak pull up and pull down
  // a floating pin follows the probe, a driven pin does not
  function automatic logic [1:0] ja_decode(input logic pu, input logic pd);
    if (pu && pd) return msoe_pkg::JA_RX;
    if (!pu && !pd) return msoe_pkg::JA_TX;
    return msoe_pkg::JA_OFF;
  endfunction

  // jitter attenuator position; the shared pin is a select in host mode,
  // so the attenuator is parked disabled there
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      jitter_atten_position_sel <= msoe_pkg::JA_OFF;
    end else begin
      jitter_atten_position_sel <= hm_s ? msoe_pkg::JA_OFF : ja_decode(pu_s, pd_s);
    end
  end

  // line code choice; only meaningful with unipolar data in hardware mode
  // unipolar comes from logic on this clock, so it is not synchronised
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_code <= msoe_pkg::MSOE_CODE_SUBST;
    end else begin
      if (hm_s || !unipolar)
        line_code <= msoe_pkg::MSOE_CODE_BIPOLAR;
      else if (code_s)
        line_code <= msoe_pkg::MSOE_CODE_AMI;
      else
        line_code <= msoe_pkg::MSOE_CODE_SUBST;
    end
  end

  // host bus style; decoded in both modes, used only in host mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_style <= msoe_pkg::MSOE_STYLE_STROBE_DIR;
    end else begin
      bus_style <= style_s ? msoe_pkg::MSOE_STYLE_RD_WR : msoe_pkg::MSOE_STYLE_STROBE_DIR;
    end
  end

  // host strobes gated by select; ignored outside host mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_acc <= '0;
    end else begin
      host_acc.sel <= hm_s && !cs_n_s;
      host_acc.data_strobe <= hm_s && !cs_n_s && !style_s && stb_s;
      host_acc.write_en <= hm_s && !cs_n_s &&
        (style_s ? stb_s : (stb_s && !rw_s));
      host_acc.read_en <= hm_s && !cs_n_s && (style_s ? rw_s : (stb_s && rw_s));
    end
  end

  // driver enables stay combinational so the global pin acts at once
  // nothing else depends on drv_enable, so the rest keeps running
  always_comb begin
    for (int i = 0; i < msoe_pkg::NPORT; i++) begin
      tx_line_drv.pos_oe_n[i] = !drv_enable ||
        (!hm_s ? 1'b0 : (output_enable_control[i] == msoe_pkg::TRI_BIT_SET));
      tx_line_drv.neg_oe_n[i] = tx_line_drv.pos_oe_n[i];
    end
  end

  global_tri_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !drv_enable |-> (&tx_line_drv.pos_oe_n && &tx_line_drv.neg_oe_n))
    else $error("drivers active while global enable low");
  port_tri_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (drv_enable && hm_s && output_enable_control[0]) |-> tx_line_drv.pos_oe_n[0])
    else $error("port 0 driver not tristated");
  sel_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cs_n_s) |-> !host_acc.sel && !host_acc.write_en)
    else $error("host access without select");
  ja_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!hm_s && pu_s && !pd_s) |=> jitter_atten_position_sel == msoe_pkg::JA_OFF)
    else $error("floating pin not disabled");
  ja_rx_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!hm_s && pu_s && pd_s) |=> jitter_atten_position_sel == msoe_pkg::JA_RX)
    else $error("high pin not receive path");
  code_ami_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!hm_s && unipolar && code_s) |=> line_code == msoe_pkg::MSOE_CODE_AMI)
    else $error("ami not selected");
  code_sub_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!hm_s && unipolar && !code_s) |=> line_code == msoe_pkg::MSOE_CODE_SUBST)
    else $error("substitution code not selected");
  style_rdwr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    style_s |=> bus_style == msoe_pkg::MSOE_STYLE_RD_WR)
    else $error("bus style wrong");
  wr_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (hm_s && !cs_n_s && style_s && stb_s) |=> host_acc.write_en && !host_acc.data_strobe)
    else $error("strobe not write enable");

  // remaining attenuator positions, host mode parks it disabled
  ja_tx_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!hm_s && !pu_s && !pd_s) |=> jitter_atten_position_sel == msoe_pkg::JA_TX)
    else $error("low pin not transmit path");
  ja_host_a: assert property (@(posedge mclk) disable iff (!rst_n)
    hm_s |=> jitter_atten_position_sel == msoe_pkg::JA_OFF)
    else $error("attenuator active in host mode");

  // outside unipolar hardware mode no line code choice applies
  code_host_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (hm_s || !unipolar) |=> line_code == msoe_pkg::MSOE_CODE_BIPOLAR)
    else $error("line code applied outside unipolar");

  // the other bus style
  style_dir_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !style_s |=> bus_style == msoe_pkg::MSOE_STYLE_STROBE_DIR)
    else $error("bus style not strobe and direction");

  // strobe pin as data strobe in strobe plus direction style, direction pin as read enable in the other style
  ds_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (hm_s && !cs_n_s && !style_s && stb_s) |=> host_acc.data_strobe)
    else $error("strobe not data strobe");
  rd_enable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (hm_s && !cs_n_s && style_s && rw_s) |=> host_acc.read_en)
    else $error("read enable not seen");

  // no strobe of any kind leaks past a high select or hardware mode
  rd_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cs_n_s) |-> !host_acc.read_en && !host_acc.data_strobe)
    else $error("read or strobe without select");
  mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(hm_s) |-> host_acc == '0)
    else $error("host access in hardware mode");

  // software bits steer every port, not just port 0
  port_tri_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (drv_enable && hm_s) |-> tx_line_drv.pos_oe_n == output_enable_control)
    else $error("port tristate does not follow its bit");
  port_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (drv_enable && !hm_s) |-> tx_line_drv.pos_oe_n == '0)
    else $error("driver off with no tristate request");

  // both legs of a pair must switch together or the line sees half a pulse
  pair_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_line_drv.pos_oe_n == tx_line_drv.neg_oe_n)
    else $error("line pair legs disagree");

  // host decode still works while the drivers are held off
  run_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!drv_enable && hm_s && !cs_n_s) |=> host_acc.sel)
    else $error("host logic stalled while tristated");
endmodule

// file: design/msoe_pkg.sv
// package for the mode strap and output enable block
package msoe_pkg;
  localparam int NPORT = 4;
  localparam logic [1:0] JA_TX = 2'h0;
  localparam logic [1:0] JA_RX = 2'h1;
  localparam logic [1:0] JA_OFF = 2'h2;
  localparam logic TRI_BIT_SET = 1'h1;
  typedef enum logic [1:0] {
    MSOE_CODE_SUBST = 2'h0,
    MSOE_CODE_AMI = 2'h1,
    MSOE_CODE_BIPOLAR = 2'h3
  } msoe_code_t;
  typedef enum logic [1:0] {
    MSOE_STYLE_STROBE_DIR = 2'h0,
    MSOE_STYLE_RD_WR = 2'h1
  } msoe_style_t;
  // decoded host-side strobes
  typedef struct packed {
    logic sel;
    logic data_strobe;
    logic write_en;
    logic read_en;
  } msoe_host_t;
  // per-port line driver controls
  typedef struct packed {
    logic [NPORT-1:0] pos_oe_n;
    logic [NPORT-1:0] neg_oe_n;
  } msoe_drv_t;
endpackage

// file: sim/msoe_strap_model.sv
// strap model: three-level pin seen through weak pull-up and pull-down
`timescale 1ns/1ns
module msoe_strap_model (
  input wire logic [1:0] lvl,
  output logic pu,
  output logic pd
);
  // lvl 0 low, 1 high, 2 floating; a float lets each pull win its own sense
  assign pu = (lvl != 2'h0);
  assign pd = (lvl == 2'h1);
endmodule

// file: sim/msoe_top_tb_top.sv
// self-checking bench for the strap decode block
`timescale 1ns/1ns
module msoe_top_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] pins = 14'h0840;
  logic pu;
  logic pd;
  msoe_pkg::msoe_host_t host_acc;
  msoe_pkg::msoe_style_t bus_style;
  logic [1:0] ja;
  msoe_pkg::msoe_code_t line_code;
  msoe_pkg::msoe_drv_t drv;
  int miscompares = 0;
  int cmp_count = 0;
  always #2 mclk = ~mclk;
  msoe_strap_model sm (.lvl(pins[5:4]), .pu(pu), .pd(pd));
  msoe_top uut (.mclk(mclk), .rst_n(rst_n), .host_mode(pins[13]), .unipolar(pins[12]),
    .chip_sel_n(pins[11]), .ja_sense_pu(pu), .ja_sense_pd(pd), .bus_style_sel(pins[10]),
    .line_code_sel(pins[9]), .strobe_pin(pins[8]), .rw_pin(pins[7]), .drv_enable(pins[6]),
    .output_enable_control(pins[3:0]), .host_acc(host_acc), .bus_style(bus_style),
    .jitter_atten_position_sel(ja), .line_code(line_code), .tx_line_drv(drv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // three edges of sync and register, one spare so the check never races
  task automatic put(input logic [13:0] v);
    @(posedge mclk);
    pins <= v;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic t_hw();
    for (int i = 0; i < 3; i++) begin
      put({3'h3, 1'h0, i[0], 3'h1, i[1:0], 4'h0});
      chk(ja, (i == 0) ? msoe_pkg::JA_TX : (i == 1) ? msoe_pkg::JA_RX : msoe_pkg::JA_OFF);
      chk(line_code, i[0] ? msoe_pkg::MSOE_CODE_AMI : msoe_pkg::MSOE_CODE_SUBST);
    end
    $display("hw strap test done");
  endtask
  task automatic t_host();
    put(14'h2540);
    chk(bus_style, msoe_pkg::MSOE_STYLE_RD_WR);
    chk({host_acc.sel, host_acc.write_en}, 8'h3);
    put(14'h2140);
    chk(bus_style, msoe_pkg::MSOE_STYLE_STROBE_DIR);
    chk({host_acc.sel, host_acc.data_strobe}, 8'h3);
    // select raised between accesses, strobe left high
    put(14'h2940);
    chk(host_acc, 8'h0);
    chk(line_code, msoe_pkg::MSOE_CODE_BIPOLAR);
    chk(ja, msoe_pkg::JA_OFF);
    // separate strobe style read access
    put(14'h24c0);
    chk({host_acc.read_en, host_acc.write_en}, 8'h2);
    // select low but hardware mode: nothing decoded
    put(14'h0140);
    chk(host_acc, 8'h0);
    $display("host test done");
  endtask
  task automatic t_rst();
    put(14'h2940);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk(host_acc, 8'h0);
    chk(ja, msoe_pkg::JA_OFF);
    chk(line_code, msoe_pkg::MSOE_CODE_SUBST);
    chk(bus_style, msoe_pkg::MSOE_STYLE_STROBE_DIR);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    put(14'h2540);
    chk({host_acc.sel, host_acc.write_en}, 8'h3);
    $display("reset test done");
  endtask
  task automatic t_drv();
    put(14'h2145);
    chk(drv, 8'h55);
    @(posedge mclk);
    pins[6] <= 1'b0;
    #1;
    chk(drv, 8'hff);
    repeat (4) @(posedge mclk);
    #1;
    chk(host_acc.sel, 8'h1);
    $display("driver test done");
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_hw();
    t_host();
    t_rst();
    t_drv();
    test_done();
  end
  // tests need about 270 ns; a hang is cut well past that
  initial begin
    #2000;
    miscompares++;
    test_done();
  end
endmodule
